// ### hw/dft_regs.vh
`ifndef DFT_REGS_VH
`define DFT_REGS_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define DFT_ADDR_CTRL     4'h0
`define DFT_ADDR_TIMEOUT  4'h4
`define DFT_ADDR_STATUS   4'h8
`define DFT_ADDR_LOCKOUT  4'hC
// Control register fields
`define DFT_CTRL_FBUS     0
`define DFT_CTRL_MB_WD    1
`define DFT_CTRL_CAN_WD   2
`define DFT_CTRL_RST_BIT  3
`define DFT_CTRL_RESET    4'h0
`define DFT_TMO_RESET     16'h03E8
// Status register fields
`define DFT_ST_LOCK       8
`define DFT_ST_OUT_EN     9
`define DFT_ST_COLD       10
`define DFT_ST_CNT_LO     12
// AXI responses
`define DFT_RESP_OKAY     2'h0
`define DFT_RESP_SLVERR   2'h2
// ****************************************
// Trip codes (value equals decimal code)
// ****************************************
`define DFT_CODE_NONE     8'h00
`define DFT_CODE_BRK_OC   8'h01
`define DFT_CODE_BRK_OVL  8'h02
`define DFT_CODE_OUT_OC   8'h03
`define DFT_CODE_MOT_OVL  8'h04
`define DFT_CODE_DC_OV    8'h06
`define DFT_CODE_DC_UV    8'h07
`define DFT_CODE_HS_OT    8'h08
`define DFT_CODE_COLD     8'h09
`define DFT_CODE_DEFAULTS 8'h0A
`define DFT_CODE_EXT      8'h0B
`define DFT_CODE_RIPPLE   8'h0D
`define DFT_CODE_PH_LOSS  8'h0E
`define DFT_CODE_HW_OC    8'h0F
`define DFT_CODE_MEM_IO   8'h11
`define DFT_CODE_AI_LOST  8'h12
`define DFT_CODE_MEM_DSP  8'h13
`define DFT_CODE_PTC      8'h15
`define DFT_CODE_FAN      8'h16
`define DFT_CODE_INT_OT   8'h17
`define DFT_CODE_OUT_FLT  8'h1A
`define DFT_CODE_AUTOTUNE 8'h29
`define DFT_CODE_MB_LOSS  8'h32
`define DFT_CODE_CAN_LOSS 8'h33
// ****************************************
// Timing
// ****************************************
`define DFT_CLK_PS        25000
`define DFT_TICK_MS       1
`define DFT_LOCK_BASE_MS  17'h0_07D0
`define DFT_LOCK_MAX_SH   3'h5
`endif

// ### hw/dft_sync3.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Three-stage pin synchroniser
// ****************************************
module dft_sync3 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Asynchronous pins and clean levels
  input  wire [W-1:0] pin_i,
  input  wire [W-1:0] reset_val,
  output reg  [W-1:0] level_q
);
  reg [W-1:0] s1_q; // Metastable stage, read only by s2_q
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  // Output moves only when stages two and three agree, filtering one-cycle glitches
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q    <= reset_val;
      s2_q    <= reset_val;
      s3_q    <= reset_val;
      level_q <= reset_val;
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= (s2_q & s3_q) | ((s2_q ^ s3_q) & level_q);
    end
  end
endmodule
`default_nettype wire

// ### hw/dft_ms_tick.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Millisecond enable divider
// ****************************************
module dft_ms_tick #(
  parameter CYC = 40000
) (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // One-cycle enable every CYC cycles
  output reg  tick_q
);
  reg [31:0] cnt_q; // Cycle counter
  // Free-running count; the pulse is a clock enable, not a clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (cnt_q == CYC - 1) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### hw/dft_trip_manager.v
// Summary of operation
// R1: Brake overcurrent trips 01, resistor overload 02
// R2: Output overcurrent 03, short-circuit overcurrent 15
// R3: Sustained motor overload above 100% trips 04
// R4: DC bus overvoltage 06, undervoltage 07
// R5: Heatsink hot 08; cold 09 inhibits start
// R6: Open external contact on input 3 trips 11
// R7: Modbus poll timeout 50, CAN timeout 51
// R8: Defaults loaded 10, ripple 13, phase loss 14
// R9: Memory faults 17 and 19, analog loss 18
// R10: PTC 21, fan 22, internal overtemperature 23
// R11: Output fault 26, autotune fault 41
// R12: Power, enable cycle or stop key reset
// R13: Fieldbus control word rising bit resets trip
// R14: Output and hardware overcurrent (03, 15) and motor overload (04) trips block reset during delay
// R15: Lockout doubles 2 to 64 seconds
// R16: Code held, output off until reset
`timescale 1ns/1ps
`default_nettype none
`include "dft_regs.vh"
module dft_trip_manager #(
  parameter TICK_CYC = (`DFT_TICK_MS * 1000000000) / `DFT_CLK_PS,
  parameter NF       = 19
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Protection sense pins, active high unless noted
  input  wire        brake_oc_i,
  input  wire        brake_resistor_overload_trip,
  input  wire        out_oc_i,
  input  wire        motor_overload_i,
  input  wire        dc_ov_i,
  input  wire        dc_uv_i,
  input  wire        heatsink_ot_i,
  input  wire        ambient_cold_i,
  input  wire        ext_contact_closed_i,
  input  wire        bus_ripple_i,
  input  wire        phase_loss_i,
  input  wire        hardware_overcurrent_trip,
  input  wire        mem_io_fault_i,
  input  wire        analog_lost_i,
  input  wire        mem_dsp_fault_i,
  input  wire        motor_ptc_i,
  input  wire        fan_fault_i,
  input  wire        internal_ot_i,
  input  wire        output_fault_i,
  input  wire        autotune_fault_i,
  // Operator pins
  input  wire        enable_i,
  input  wire        stop_key_i,
  // Same-clock events from parameter and fieldbus logic
  input  wire        defaults_loaded_i,
  input  wire        modbus_poll_i,
  input  wire        can_frame_i,
  // Drive status
  output reg  [7:0]  trip_code_q,
  output wire        no_fault_indication,
  output wire        output_enable,
  output wire        start_inhibit
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  wire [NF-1:0] raw_pins;  // Fault pins, bit order matches code table
  wire [NF-1:0] flt;       // Clean fault levels
  wire [1:0]    op;        // Clean enable and stop key
  wire          tick;      // Millisecond enable
  assign raw_pins = {output_fault_i, internal_ot_i, fan_fault_i, motor_ptc_i, mem_dsp_fault_i,
                     analog_lost_i, mem_io_fault_i, hardware_overcurrent_trip, phase_loss_i,
                     bus_ripple_i, ~ext_contact_closed_i, ambient_cold_i, heatsink_ot_i,
                     dc_uv_i, dc_ov_i, motor_overload_i, out_oc_i,
                     brake_resistor_overload_trip, brake_oc_i};
  dft_sync3 #(.W(NF)) u_sync_flt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_i     (raw_pins),
    .reset_val ({NF{1'b0}}),
    .level_q   (flt)
  );
  dft_sync3 #(.W(2)) u_sync_op (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_i     ({stop_key_i, enable_i}),
    .reset_val (2'h0),
    .level_q   (op)
  );
  dft_ms_tick #(.CYC(TICK_CYC)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick_q  (tick)
  );
  // ****************************************
  // Fault priority encoding
  // ****************************************
  // Lowest code wins when several faults rise together
  function [7:0] dft_encode;
    input [NF-1:0] f;
    input          dflt;
    input          mb;
    input          can;
    begin
      dft_encode = `DFT_CODE_NONE;
      if (can)          dft_encode = `DFT_CODE_CAN_LOSS; // R7
      if (mb)           dft_encode = `DFT_CODE_MB_LOSS; // R7
      if (f[18])        dft_encode = `DFT_CODE_OUT_FLT; // R11
      if (f[17])        dft_encode = `DFT_CODE_INT_OT; // R10
      if (f[16])        dft_encode = `DFT_CODE_FAN; // R10
      if (f[15])        dft_encode = `DFT_CODE_PTC; // R10
      if (f[14])        dft_encode = `DFT_CODE_MEM_DSP; // R9
      if (f[13])        dft_encode = `DFT_CODE_AI_LOST; // R9
      if (f[12])        dft_encode = `DFT_CODE_MEM_IO; // R9
      if (f[11])        dft_encode = `DFT_CODE_HW_OC; // R2
      if (f[10])        dft_encode = `DFT_CODE_PH_LOSS; // R8
      if (f[9])         dft_encode = `DFT_CODE_RIPPLE; // R8
      if (f[8])         dft_encode = `DFT_CODE_EXT; // R6
      if (dflt)         dft_encode = `DFT_CODE_DEFAULTS; // R8
      if (f[7])         dft_encode = `DFT_CODE_COLD; // R5
      if (f[6])         dft_encode = `DFT_CODE_HS_OT; // R5
      if (f[5])         dft_encode = `DFT_CODE_DC_UV; // R4
      if (f[4])         dft_encode = `DFT_CODE_DC_OV; // R4
      if (f[3])         dft_encode = `DFT_CODE_MOT_OVL; // R3
      if (f[2])         dft_encode = `DFT_CODE_OUT_OC; // R2
      if (f[1])         dft_encode = `DFT_CODE_BRK_OVL; // R1
      if (f[0])         dft_encode = `DFT_CODE_BRK_OC; // R1
    end
  endfunction
  // Autotune has no dedicated pin slot in the vector; it ranks just above the comms losses
  reg        mb_loss;      // Modbus watchdog expired
  reg        can_loss;     // CAN watchdog expired
  wire [7:0] new_code;     // Encoded pending fault
  assign new_code = (dft_encode(flt, defaults_loaded_i, 1'b0, 1'b0) != `DFT_CODE_NONE) ?
                    dft_encode(flt, defaults_loaded_i, 1'b0, 1'b0) :
                    (autotune_fault_i ? `DFT_CODE_AUTOTUNE : // R11
                     dft_encode({NF{1'b0}}, 1'b0, mb_loss, can_loss));
  // ****************************************
  // Registers written by software and internal state
  // ****************************************
  reg  [3:0]  ctrl_q;      // Fieldbus, watchdog enables, control word reset bit
  reg  [15:0] tmo_q;       // Comms timeout in ms
  reg  [15:0] mb_cnt_q;    // Ms since last Modbus poll
  reg  [15:0] can_cnt_q;   // Ms since last CAN frame
  wire        lock_active; // Reset lockout running
  reg  [2:0]  trip_cnt_q;  // Repeat count of lockout trips, saturates
  reg  [16:0] lock_ms_q;   // Remaining lockout time in ms
  reg  [1:0]  op_d1_q;     // Previous enable and stop key levels
  reg         fb_rst_q;    // Control word rising-edge request
  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  reg         aw_hold_q;   // Address taken, waiting for data
  reg         w_hold_q;    // Data taken, waiting for address
  reg  [3:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  wire        wr_go;       // Both halves present, response free
  assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  // Accept address and data in any order; answer once both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DFT_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only control and timeout are writable; others are errors
        s_axi_bresp  <= (awaddr_q == `DFT_ADDR_CTRL || awaddr_q == `DFT_ADDR_TIMEOUT) ?
                        `DFT_RESP_OKAY : `DFT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Register store with byte enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= `DFT_CTRL_RESET;
      tmo_q    <= `DFT_TMO_RESET;
      fb_rst_q <= 1'b0;
    end else begin
      fb_rst_q <= 1'b0;
      if (wr_go && awaddr_q == `DFT_ADDR_CTRL && wstrb_q[0]) begin
        ctrl_q   <= wdata_q[3:0];
        // Only a 0 to 1 change of the reset bit counts, and only under fieldbus control
        fb_rst_q <= ctrl_q[`DFT_CTRL_FBUS] & wdata_q[`DFT_CTRL_FBUS] & // R13
                    ~ctrl_q[`DFT_CTRL_RST_BIT] & wdata_q[`DFT_CTRL_RST_BIT];
      end
      if (wr_go && awaddr_q == `DFT_ADDR_TIMEOUT) begin
        if (wstrb_q[0]) tmo_q[7:0]  <= wdata_q[7:0];
        if (wstrb_q[1]) tmo_q[15:8] <= wdata_q[15:8];
      end
    end
  end
  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DFT_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DFT_RESP_OKAY;
        case (s_axi_araddr)
          `DFT_ADDR_CTRL:    s_axi_rdata <= {28'h000_0000, ctrl_q};
          `DFT_ADDR_TIMEOUT: s_axi_rdata <= {16'h0000, tmo_q};
          `DFT_ADDR_STATUS:  s_axi_rdata <= {17'h0_0000, trip_cnt_q, 1'b0, start_inhibit,
                                             output_enable, lock_active, trip_code_q};
          `DFT_ADDR_LOCKOUT: s_axi_rdata <= {15'h0000, lock_ms_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DFT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // Fieldbus watchdogs
  // ****************************************
  // Counts stall at the limit so a lost link keeps asserting its loss
  always @(posedge aclk) begin
    if (!aresetn) begin
      mb_cnt_q  <= 16'h0000;
      can_cnt_q <= 16'h0000;
      mb_loss   <= 1'b0;
      can_loss  <= 1'b0;
    end else begin
      if (modbus_poll_i || !ctrl_q[`DFT_CTRL_MB_WD])
        mb_cnt_q <= 16'h0000;
      else if (tick && mb_cnt_q != tmo_q)
        mb_cnt_q <= mb_cnt_q + 16'h0001;
      if (can_frame_i || !ctrl_q[`DFT_CTRL_CAN_WD])
        can_cnt_q <= 16'h0000;
      else if (tick && can_cnt_q != tmo_q)
        can_cnt_q <= can_cnt_q + 16'h0001;
      mb_loss  <= ctrl_q[`DFT_CTRL_MB_WD] & ~modbus_poll_i & (mb_cnt_q == tmo_q); // R7
      can_loss <= ctrl_q[`DFT_CTRL_CAN_WD] & ~can_frame_i & (can_cnt_q == tmo_q); // R7
    end
  end
  // ****************************************
  // Reset requests and lockout
  // ****************************************
  wire rst_req;            // Any reset request this cycle
  wire lock_trip;          // New trip is one of the lockout codes
  assign lock_active = (lock_ms_q != 17'h0_0000);
  // Enable rising edge means it was removed and reapplied; stop key on its press
  assign rst_req = (op[0] & ~op_d1_q[0]) | (op[1] & ~op_d1_q[1]) | fb_rst_q; // R12
  assign lock_trip = (new_code == `DFT_CODE_OUT_OC) | (new_code == `DFT_CODE_MOT_OVL) |
                     (new_code == `DFT_CODE_HW_OC); // R14
  // Trip latch: the first code is held, later faults do not overwrite it
  always @(posedge aclk) begin
    if (!aresetn) begin
      // Power-up clears trip and repeat count
      trip_code_q <= `DFT_CODE_NONE; // R12
      trip_cnt_q  <= 3'h0;
      lock_ms_q   <= 17'h0_0000;
      op_d1_q     <= 2'h0;
    end else begin
      op_d1_q <= op;
      if (trip_code_q == `DFT_CODE_NONE) begin
        if (new_code != `DFT_CODE_NONE) begin
          trip_code_q <= new_code; // R16
          if (lock_trip) begin
            // 2 s shifted by the repeat count, capped at 64 s
            lock_ms_q <= `DFT_LOCK_BASE_MS << trip_cnt_q; // R15
            if (trip_cnt_q != `DFT_LOCK_MAX_SH)
              trip_cnt_q <= trip_cnt_q + 3'h1; // R15
          end
        end
      end else if (rst_req && !lock_active) begin
        // A still-present fault simply trips again on the next cycle
        trip_code_q <= `DFT_CODE_NONE; // R14
      end
      if (tick && lock_active)
        lock_ms_q <= lock_ms_q - 17'h0_0001;
    end
  end
  // ****************************************
  // Drive outputs
  // ****************************************
  assign no_fault_indication = (trip_code_q == `DFT_CODE_NONE);
  // Cold ambient blocks start even after the trip itself is reset
  assign start_inhibit = flt[7]; // R5
  assign output_enable = no_fault_indication & op[0] & ~start_inhibit; // R16
endmodule
`default_nettype wire

// ### test/dft_trip_manager_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the trip manager
// ****************************************
module dft_trip_checker #(
  parameter TICK_CYC = 40000
) (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Pins that cause or clear trips
  input wire logic       brake_oc_i,
  input wire logic       ext_contact_closed_i,
  input wire logic       ambient_cold_i,
  input wire logic       enable_i,
  input wire logic       stop_key_i,
  // Drive status
  input wire logic [7:0] trip_code_q,
  input wire logic       no_fault_indication,
  input wire logic       output_enable,
  input wire logic       start_inhibit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // One tick of slack, the divider phase is unknown at the trip
  localparam int LOCK_CYC = 1999 * TICK_CYC;
  int          lock_cnt_q;   // Cycles spent under a lockout code
  wire         lock_code = trip_code_q == 8'h03 || trip_code_q == 8'h04 || trip_code_q == 8'h0F;
  // Count only while a lockout trip is held; int so real 1 ms ticks fit
  always @(posedge aclk) lock_cnt_q <= (!aresetn || !lock_code) ? 0 : lock_cnt_q + 1;
  a_flag_code: assert property (no_fault_indication == (trip_code_q == 8'h00))
    else $error("no fault flag wrong");
  a_out_off: assert property (trip_code_q != 8'h00 |-> !output_enable)
    else $error("output on while tripped");
  a_code_held: assert property (trip_code_q != 8'h00 |=>
    trip_code_q == $past(trip_code_q) || trip_code_q == 8'h00)
    else $error("trip code changed");
  a_cold_inhibit: assert property (ambient_cold_i [*6] |-> start_inhibit)
    else $error("cold not inhibiting");
  a_inhibit_out: assert property (start_inhibit |-> !output_enable)
    else $error("output on while inhibited");
  a_brake_trip: assert property ((brake_oc_i && trip_code_q == 8'h00) [*4]
    |-> ##[1:3] trip_code_q == 8'h01)
    else $error("brake trip missing");
  a_ext_trip: assert property ((!ext_contact_closed_i && trip_code_q == 8'h00) [*4]
    |-> ##[1:3] trip_code_q == 8'h0B)
    else $error("external trip missing");
  a_stop_clear: assert property ($rose(stop_key_i) && trip_code_q != 8'h00 && !lock_code
    |-> ##[2:6] trip_code_q == 8'h00)
    else $error("stop key clear missing");
  a_enable_clear: assert property ($rose(enable_i) && trip_code_q != 8'h00 && !lock_code
    |-> ##[2:6] trip_code_q == 8'h00)
    else $error("enable clear missing");
  a_lock_hold: assert property (lock_code && lock_cnt_q < LOCK_CYC |=>
    trip_code_q != 8'h00)
    else $error("cleared in lockout");
endmodule
bind dft_trip_manager dft_trip_checker #(.TICK_CYC(TICK_CYC)) dft_trip_checker_i (.*);
`default_nettype wire

// ### test/dft_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Fieldbus master traffic model
// ****************************************
module dft_far_model #(
  parameter int GAP = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Traffic enables from the bench
  input wire logic mb_run,
  input wire logic can_run,
  // One-cycle traffic pulses
  output var logic modbus_poll,
  output var logic can_frame
);
  logic [7:0] gap_q;   // Cycles since the last poll slot
  // Polls stay cyclic while running, a stopped master is silent
  always @(posedge aclk) begin
    if (!aresetn || gap_q == GAP[7:0] - 8'h01) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
    modbus_poll <= aresetn && mb_run && gap_q == 8'h00;
    can_frame <= aresetn && can_run && gap_q == 8'h00;
  end
endmodule
`default_nettype wire

// ### test/dft_trip_manager_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dft_regs.vh"
module dft_trip_manager_tb;
  localparam int TICK = 4;   // Short millisecond so lockouts fit the run
  localparam logic [7:0] CODE [20] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h1A, 8'h29};
  localparam int LK [3] = '{2, 3, 11};   // Pins whose trips carry a lockout
  logic        aclk, aresetn, enable_i, stop_key_i, dflt, mb_run, can_run, mb_poll, can_pulse;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [19:0] flt;   // Fault pins, asserted state is always 1 here
  logic [7:0]  trip_code_q;
  logic        no_fault_indication, output_enable, start_inhibit;
  int          failures, checks, cyc;
  dft_trip_manager #(.TICK_CYC(TICK)) dft_trip_manager_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .brake_oc_i(flt[0]), .brake_resistor_overload_trip(flt[1]),
    .out_oc_i(flt[2]), .motor_overload_i(flt[3]), .dc_ov_i(flt[4]), .dc_uv_i(flt[5]),
    .heatsink_ot_i(flt[6]), .ambient_cold_i(flt[7]), .ext_contact_closed_i(~flt[8]),
    .bus_ripple_i(flt[9]), .phase_loss_i(flt[10]), .hardware_overcurrent_trip(flt[11]),
    .mem_io_fault_i(flt[12]), .analog_lost_i(flt[13]), .mem_dsp_fault_i(flt[14]),
    .motor_ptc_i(flt[15]), .fan_fault_i(flt[16]), .internal_ot_i(flt[17]),
    .output_fault_i(flt[18]), .autotune_fault_i(flt[19]), .enable_i, .stop_key_i,
    .defaults_loaded_i(dflt), .modbus_poll_i(mb_poll), .can_frame_i(can_pulse),
    .trip_code_q, .no_fault_indication, .output_enable, .start_inhibit
  );
  dft_far_model dft_far_model_i (
    .aclk, .aresetn, .mb_run, .can_run, .modbus_poll(mb_poll), .can_frame(can_pulse)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_trip;
    int n;
    n = 0;
    while (trip_code_q === 8'h00 && n < 12) begin
      @(posedge aclk);
      n++;
    end
  endtask
  // Enable cycle or stop key press, held long enough for the pin filter
  task automatic press(input logic use_en);
    if (use_en) enable_i <= 1'b0;
    else stop_key_i <= 1'b1;
    repeat (6) @(posedge aclk);
    if (use_en) enable_i <= 1'b1;
    else stop_key_i <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(`DFT_ADDR_CTRL, d, r);
    chk(d, 32'h0000_0000);
    axi_rd(`DFT_ADDR_TIMEOUT, d, r);
    chk(d, 32'h0000_03E8);
    axi_wr(`DFT_ADDR_STATUS, 32'h0000_00FF, r);
    chk(r, `DFT_RESP_SLVERR);
    axi_rd(`DFT_ADDR_STATUS, d, r);
    chk(d, 32'h0000_0200);
  endtask
  // Each non-lockout pin; clears alternate key and enable
  task automatic t_codes;
    for (int i = 0; i < 20; i++) begin
      if (i == 2 || i == 3 || i == 11) continue;
      flt[i] <= 1'b1;
      wait_trip();
      chk(trip_code_q, CODE[i]);
      chk(output_enable, 1'b0);
      if (i == 7) chk(start_inhibit, 1'b1);
      flt[i] <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(trip_code_q, CODE[i]);
      press(i[0]);
      chk(trip_code_q, 8'h00);
      chk(output_enable, 1'b1);
    end
  endtask
  task automatic t_bus;
    logic [1:0] r;
    dflt <= 1'b1;
    @(posedge aclk);
    dflt <= 1'b0;
    wait_trip();
    chk(trip_code_q, `DFT_CODE_DEFAULTS);
    press(1'b0);
    axi_wr(`DFT_ADDR_TIMEOUT, 32'h0000_0005, r);
    mb_run <= 1'b1;
    can_run <= 1'b1;
    axi_wr(`DFT_ADDR_CTRL, 32'h0000_0007, r);
    repeat (200) @(posedge aclk);
    chk(trip_code_q, 8'h00);
    mb_run <= 1'b0;
    repeat (48) @(posedge aclk);
    chk(trip_code_q, `DFT_CODE_MB_LOSS);
    axi_wr(`DFT_ADDR_CTRL, 32'h0000_0001, r);
    axi_wr(`DFT_ADDR_CTRL, 32'h0000_0009, r);
    repeat (4) @(posedge aclk);
    chk(trip_code_q, 8'h00);
    can_run <= 1'b0;
    axi_wr(`DFT_ADDR_CTRL, 32'h0000_0005, r);
    repeat (48) @(posedge aclk);
    chk(trip_code_q, `DFT_CODE_CAN_LOSS);
    axi_wr(`DFT_ADDR_CTRL, 32'h0000_0000, r);
    press(1'b0);
    chk(trip_code_q, 8'h00);
  endtask
  // Three lockout trips, each window doubling
  task automatic t_lock;
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 3; k++) begin
      flt[LK[k]] <= 1'b1;
      wait_trip();
      flt[LK[k]] <= 1'b0;
      chk(trip_code_q, CODE[LK[k]]);
      axi_rd(`DFT_ADDR_LOCKOUT, d, r);
      chk(d > (32'h0000_07D0 << k) - 4 && d <= (32'h0000_07D0 << k), 1'b1);
      press(1'b0);
      chk(trip_code_q, CODE[LK[k]]);
      if (k < 2) begin
        repeat ((2000 << k) * TICK) @(posedge aclk);
        press(1'b0);
        chk(trip_code_q, 8'h00);
      end
    end
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(trip_code_q, 8'h00);
  endtask
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    {aclk, aresetn, stop_key_i, dflt, mb_run, can_run} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h000_0000_0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    flt = 20'h0_0000;
    enable_i = 1'b1;
    failures = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_codes();
    t_bus();
    t_lock();
    close_out();
  end
endmodule
`default_nettype wire
